// ---- verilog/iep_pkg.sv ----
// Shared constants and types for the inadvertent energizing protection block
package iep_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CUR_THR  = 8'h04;
  localparam logic [7:0] ADDR_VOLT_THR = 8'h08;
  localparam logic [7:0] ADDR_PICKUP   = 8'h0c;
  localparam logic [7:0] ADDR_DROPOUT  = 8'h10;
  localparam logic [7:0] ADDR_STATE    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

  //////////////////////////////////////////////////////////////////////////////
  // Operation select codes
  localparam logic [1:0] OP_OFF  = 2'h0;
  localparam logic [1:0] OP_PEAK = 2'h1;
  localparam logic [1:0] OP_FUND = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Setting ranges and reset values
  localparam logic [15:0] CUR_THR_MIN  = 16'h0014;
  localparam logic [15:0] CUR_THR_MAX  = 16'h0bb8;
  localparam logic [15:0] CUR_THR_RST  = 16'h00c8;
  localparam logic [15:0] VOLT_THR_MIN = 16'h001e;
  localparam logic [15:0] VOLT_THR_MAX = 16'h0082;
  localparam logic [15:0] VOLT_THR_RST = 16'h005a;
  localparam logic [15:0] DELAY_MIN    = 16'h0000;
  localparam logic [15:0] DELAY_MAX    = 16'h7530;
  localparam logic [15:0] PICKUP_RST   = 16'h03e8;
  localparam logic [15:0] DROPOUT_RST  = 16'h0064;

  // Hysteresis ratios in percent
  localparam logic [7:0] OC_RESET_PCT = 8'h55;
  localparam logic [7:0] UV_RESET_PCT = 8'h69;
  localparam logic [7:0] PCT_FULL     = 8'h64;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int IRQ_TRIP   = 0;
  localparam int IRQ_ARMED  = 1;
  localparam int IRQ_BITS   = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int PCLK_PERIOD_NS = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES      = MS_NS / PCLK_PERIOD_NS;

  // Sampled measurements, all in percent of nominal
  typedef struct packed {
    logic [2:0][15:0] volt;
    logic [2:0][15:0] cur_peak;
    logic [2:0][15:0] cur_fund;
  } iep_meas_t;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

// ---- verilog/iep_timer.sv ----
// Pickup and dropout delay timer counted in millisecond ticks
`timescale 1ns/1ns
`default_nettype none

module iep_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ms_tick,
  input  wire logic        clear,
  input  wire logic        cond,
  input  wire logic [15:0] pickup_ms,
  input  wire logic [15:0] dropout_ms,
  output logic             out_q
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        out_d;
  logic [15:0] limit;
  logic        expired;

  // Delay that applies to the pending change
  assign limit   = cond ? pickup_ms : dropout_ms;
  assign expired = (cnt_q >= limit);

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (clear) begin
      cnt_d = 16'h0000;
      out_d = 1'b0;
    end else if (cond == out_q) begin
      cnt_d = 16'h0000;
    end else if (expired) begin
      cnt_d = 16'h0000;
      out_d = cond;
    end else if (ms_tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/iep_top.sv ----
// Inadvertent energizing protection with APB settings and interrupt
// Summary of operation
// - All three phases low starts pickup timer
// - Timer output true enables overcurrent stage
// - Overcurrent during dropout window issues trip
// - Trip lasts dropout time, then forced off
// - Operation select: off, peak, fundamental; off
// - Current threshold 20 to 3000, default 200
// - Voltage threshold 30 to 130, default 90
// - Pickup delay 0 to 30000 ms, default 1000
// - Dropout delay 0 to 30000 ms, default 100
// - Overcurrent resets below 0.85 of threshold
// - Undervoltage resets above 1.05 of threshold
// - Delays accurate to 5% or 15 ms
// - Separate trip per phase from own overcurrent
// - User block disables function, trips inactive
// - VT failure input disables the function
// - Off selection keeps function fully inactive
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module iep_top #(
  parameter int TICK_CYCLES = iep_pkg::MS_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire iep_pkg::iep_meas_t meas,
  input  wire logic              user_block,
  input  wire logic              vt_failure_block,
  output logic                   trip_phase_1,
  output logic                   trip_phase_2,
  output logic                   trip_phase_3,
  output logic                   general_trip,
  output logic                   irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_ctrl;
  logic        hit_cur;
  logic        hit_volt;
  logic        hit_pick;
  logic        hit_drop;
  logic        hit_state;
  logic        hit_istat;
  logic        hit_imask;
  logic        mapped;
  logic [15:0] wdat16;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc    = access_ph && pwrite;
  assign rd_acc    = access_ph && !pwrite;
  assign hit_ctrl  = (paddr == iep_pkg::ADDR_CTRL);
  assign hit_cur   = (paddr == iep_pkg::ADDR_CUR_THR);
  assign hit_volt  = (paddr == iep_pkg::ADDR_VOLT_THR);
  assign hit_pick  = (paddr == iep_pkg::ADDR_PICKUP);
  assign hit_drop  = (paddr == iep_pkg::ADDR_DROPOUT);
  assign hit_state = (paddr == iep_pkg::ADDR_STATE);
  assign hit_istat = (paddr == iep_pkg::ADDR_IRQ_STAT);
  assign hit_imask = (paddr == iep_pkg::ADDR_IRQ_MASK);
  assign mapped    = hit_ctrl | hit_cur | hit_volt | hit_pick | hit_drop | hit_state
                   | hit_istat | hit_imask;
  assign wdat16    = pwdata[15:0];
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;

  //////////////////////////////////////////////////////////////////////////////
  // Settings registers
  logic [1:0]  op_q;
  logic [15:0] cur_thr_q;
  logic [15:0] volt_thr_q;
  logic [15:0] pickup_q;
  logic [15:0] dropout_q;
  logic [1:0]  op_wr;

  // Unused code 3 falls back to off
  assign op_wr = (pwdata[1:0] == iep_pkg::OP_PEAK || pwdata[1:0] == iep_pkg::OP_FUND) ?
                 pwdata[1:0] : iep_pkg::OP_OFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q       <= iep_pkg::OP_OFF;
      cur_thr_q  <= iep_pkg::CUR_THR_RST;
      volt_thr_q <= iep_pkg::VOLT_THR_RST;
      pickup_q   <= iep_pkg::PICKUP_RST;
      dropout_q  <= iep_pkg::DROPOUT_RST;
    end else if (wr_acc) begin
      if (hit_ctrl) op_q <= op_wr;
      if (hit_cur) cur_thr_q <= iep_pkg::clamp(wdat16, iep_pkg::CUR_THR_MIN,
                                               iep_pkg::CUR_THR_MAX);
      if (hit_volt) volt_thr_q <= iep_pkg::clamp(wdat16, iep_pkg::VOLT_THR_MIN,
                                                 iep_pkg::VOLT_THR_MAX);
      if (hit_pick) pickup_q <= iep_pkg::clamp(wdat16, iep_pkg::DELAY_MIN,
                                               iep_pkg::DELAY_MAX);
      if (hit_drop) dropout_q <= iep_pkg::clamp(wdat16, iep_pkg::DELAY_MIN,
                                                iep_pkg::DELAY_MAX);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick for the delay timer
  logic [TW-1:0] pre_q;
  logic          ms_tick;

  assign ms_tick = (pre_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= ms_tick ? '0 : pre_q + TW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-phase detectors with hysteresis
  logic        disabled;
  logic [2:0]  uv_q;
  logic [2:0]  uv_d;
  logic [2:0]  oc_q;
  logic [2:0]  oc_d;
  logic [23:0] cur_off_lvl;
  logic [23:0] volt_off_lvl;

  assign disabled     = user_block || vt_failure_block || (op_q == iep_pkg::OP_OFF);
  assign cur_off_lvl  = 24'(cur_thr_q) * 24'(iep_pkg::OC_RESET_PCT);
  assign volt_off_lvl = 24'(volt_thr_q) * 24'(iep_pkg::UV_RESET_PCT);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      logic [15:0] cur;
      logic [23:0] cur_pct;
      logic [23:0] volt_pct;

      // Mode picks the current quantity
      assign cur      = (op_q == iep_pkg::OP_FUND) ? meas.cur_fund[gi] : meas.cur_peak[gi];
      assign cur_pct  = 24'(cur) * 24'(iep_pkg::PCT_FULL);
      assign volt_pct = 24'(meas.volt[gi]) * 24'(iep_pkg::PCT_FULL);
      assign oc_d[gi] = disabled ? 1'b0 :
                        oc_q[gi] ? !(cur_pct < cur_off_lvl) : (cur > cur_thr_q);
      assign uv_d[gi] = disabled ? 1'b0 :
                        uv_q[gi] ? !(volt_pct > volt_off_lvl) : (meas.volt[gi] < volt_thr_q);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q <= 3'h0;
      oc_q <= 3'h0;
    end else begin
      uv_q <= uv_d;
      oc_q <= oc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Voltage-loss timer
  logic all_low;
  logic armed_q;

  assign all_low = &uv_q;

  iep_timer u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .ms_tick    (ms_tick),
    .clear      (disabled),
    .cond       (all_low),
    .pickup_ms  (pickup_q),
    .dropout_ms (dropout_q),
    .out_q      (armed_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Trip decision
  logic [2:0] trip_q;
  logic [2:0] trip_d;
  logic       gen_q;

  assign trip_d = (armed_q && !disabled) ? oc_q : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= 3'h0;
      gen_q  <= 1'b0;
    end else begin
      trip_q <= trip_d;
      gen_q  <= |trip_d;
    end
  end

  assign trip_phase_1 = trip_q[0];
  assign trip_phase_2 = trip_q[1];
  assign trip_phase_3 = trip_q[2];
  assign general_trip = gen_q;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and read data
  logic [iep_pkg::IRQ_BITS-1:0] istat_q;
  logic [iep_pkg::IRQ_BITS-1:0] imask_q;
  logic [iep_pkg::IRQ_BITS-1:0] ievt;
  logic [iep_pkg::IRQ_BITS-1:0] iclr;
  logic                         armed_d1_q;
  logic                         irq_q;
  logic [31:0]                  rd_mux;
  logic [31:0]                  prdata_q;

  assign ievt[iep_pkg::IRQ_TRIP]  = (|trip_d) && !gen_q;
  assign ievt[iep_pkg::IRQ_ARMED] = armed_q && !armed_d1_q;
  // Clear only what the read reported, so an event landing at the setup edge survives
  assign iclr = (rd_acc && hit_istat) ? prdata_q[iep_pkg::IRQ_BITS-1:0] : '0;

  assign rd_mux = hit_ctrl  ? {30'h0, op_q} :
                  hit_cur   ? {16'h0, cur_thr_q} :
                  hit_volt  ? {16'h0, volt_thr_q} :
                  hit_pick  ? {16'h0, pickup_q} :
                  hit_drop  ? {16'h0, dropout_q} :
                  hit_state ? {21'h0, armed_q, gen_q, trip_q, oc_q, uv_q} :
                  hit_istat ? {30'h0, istat_q} :
                  hit_imask ? {30'h0, imask_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q    <= '0;
      imask_q    <= '0;
      armed_d1_q <= 1'b0;
      irq_q      <= 1'b0;
      prdata_q   <= 32'h0;
    end else begin
      // New event wins over a clearing read
      istat_q    <= (istat_q & ~iclr) | ievt;
      armed_d1_q <= armed_q;
      irq_q      <= |(((istat_q & ~iclr) | ievt) & imask_q);
      if (wr_acc && hit_imask) imask_q <= pwdata[iep_pkg::IRQ_BITS-1:0];
      if (setup_ph) prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign irq    = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_user_block;
    user_block |=> (trip_q == 3'h0) && !gen_q;
  endproperty
  a_user_block: assert property (p_user_block) else $error("Trip while user block");

  property p_vt_block;
    vt_failure_block |=> (oc_q == 3'h0) && (uv_q == 3'h0) && (trip_q == 3'h0) && !gen_q;
  endproperty
  a_vt_block: assert property (p_vt_block) else $error("Function live in VT failure");

  property p_off_inactive;
    (op_q == iep_pkg::OP_OFF) |=> !armed_q && (trip_q == 3'h0);
  endproperty
  a_off_inactive: assert property (p_off_inactive) else $error("Active while off");

  property p_gen_or;
    gen_q == (|trip_q);
  endproperty
  a_gen_or: assert property (p_gen_or) else $error("General trip not OR of phases");

  property p_trip_needs_armed;
    (|trip_q) |-> $past(armed_q);
  endproperty
  a_trip_needs_armed: assert property (p_trip_needs_armed) else $error("Trip without timer");

  property p_trip_on_oc;
    (armed_q && !disabled && oc_q[1]) |=> trip_q[1];
  endproperty
  a_trip_on_oc: assert property (p_trip_on_oc) else $error("Overcurrent did not trip");

  property p_trip_ends;
    !armed_q |=> (trip_q == 3'h0);
  endproperty
  a_trip_ends: assert property (p_trip_ends) else $error("Trip after dropout");

  property p_phase_own;
    trip_q[0] |-> $past(oc_q[0]);
  endproperty
  a_phase_own: assert property (p_phase_own) else $error("Phase trip without own overcurrent");

  property p_arm_all_low;
    $rose(armed_q) |-> $past(all_low);
  endproperty
  a_arm_all_low: assert property (p_arm_all_low) else $error("Timer set without all low");

  property p_ranges;
    (cur_thr_q >= iep_pkg::CUR_THR_MIN) && (cur_thr_q <= iep_pkg::CUR_THR_MAX) &&
    (volt_thr_q >= iep_pkg::VOLT_THR_MIN) && (volt_thr_q <= iep_pkg::VOLT_THR_MAX);
  endproperty
  a_ranges: assert property (p_ranges) else $error("Threshold out of range");

  property p_delay_range;
    (pickup_q <= iep_pkg::DELAY_MAX) && (dropout_q <= iep_pkg::DELAY_MAX);
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("Delay out of range");

  property p_oc_hold;
    (oc_q[2] && !disabled && !(g_phase[2].cur_pct < cur_off_lvl)) |=> oc_q[2];
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("Overcurrent dropped early");

  property p_uv_hold;
    (uv_q[0] && !disabled && !(g_phase[0].volt_pct > volt_off_lvl)) |=> uv_q[0];
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("Undervoltage dropped early");

  property p_tick;
    ms_tick |=> !ms_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("Tick too frequent");

  c_trip: cover property ($rose(gen_q));
  c_armed: cover property ($rose(armed_q));
  c_trip_end: cover property ($fell(gen_q) && !armed_q);
  c_irq: cover property ($rose(irq_q));

endmodule

`default_nettype wire

// ---- verif/iep_far_side.sv ----
// Far-side model: measurement front end and trip receiver
`timescale 1ns/1ns
`default_nettype none

module iep_far_side (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [2:0][15:0]  volt_set,
  input  wire logic [2:0][15:0]  peak_set,
  input  wire logic [2:0][15:0]  fund_set,
  input  wire logic              trip_phase_1,
  input  wire logic              trip_phase_2,
  input  wire logic              trip_phase_3,
  input  wire logic              general_trip,
  output var iep_pkg::iep_meas_t meas,
  output logic      [2:0]        seen_q,
  output logic      [31:0]       width_q,
  output logic                   pulse_end
);
  logic        gen_q;
  logic [31:0] run_q;

  //////////////////////////////////////////////////////////////////////////////
  // Samples reach the relay one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas <= '0;
    end else begin
      meas.volt     <= volt_set;
      meas.cur_peak <= peak_set;
      meas.cur_fund <= fund_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trip receiver: width and phases of each general trip pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q     <= 1'b0;
      run_q     <= '0;
      seen_q    <= '0;
      width_q   <= '0;
      pulse_end <= 1'b0;
    end else begin
      gen_q     <= general_trip;
      pulse_end <= gen_q & ~general_trip;
      if (general_trip) begin
        run_q  <= run_q + 32'h1;
        seen_q <= (gen_q ? seen_q : 3'h0) | {trip_phase_3, trip_phase_2, trip_phase_1};
      end else if (gen_q) begin
        width_q <= run_q;
        run_q   <= '0;
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/inadvertent_energizing_trip_bench.sv ----
// Self-checking bench for the inadvertent energizing trip block
`timescale 1ns/1ns
`default_nettype none

module inadvertent_energizing_trip_bench;
  localparam int TICK = 10;
  localparam int PICK = 3;
  localparam int DROP = 2;
  localparam int ARM  = (PICK + 1) * TICK + 6;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} iep_apb_exp_t;
  typedef struct {logic [2:0] seen; int wmin; int wmax;} iep_pulse_exp_t;
  localparam logic [7:0] CA [7] = '{iep_pkg::ADDR_CTRL, iep_pkg::ADDR_CUR_THR,
    iep_pkg::ADDR_CUR_THR, iep_pkg::ADDR_VOLT_THR, iep_pkg::ADDR_VOLT_THR,
    iep_pkg::ADDR_PICKUP, iep_pkg::ADDR_DROPOUT};
  localparam logic [31:0] CW [7] = '{32'h3, 32'h13, 32'hbb9, 32'h1d, 32'h83, 32'h7531, 32'h0};
  localparam logic [31:0] CE [7] = '{32'h0, 32'h14, 32'hbb8, 32'h1e, 32'h82, 32'h7530, 32'h0};
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, width_q, msk;
  logic               user_block, vt_failure_block, general_trip, pulse_end;
  logic               trip_phase_1, trip_phase_2, trip_phase_3;
  logic [2:0]         seen_q;
  logic [2:0][15:0]   volt_set, peak_set, fund_set, pk, fd, vv;
  logic [15:0]        lo, hi, rv;
  iep_pkg::iep_meas_t meas;
  int                 errors, check_count;
  iep_apb_exp_t       apb_q[$];
  iep_pulse_exp_t     pulse_q[$];
  iep_apb_exp_t       ae;
  iep_pulse_exp_t     pe;

  iep_top #(.TICK_CYCLES(TICK)) u_iep_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .meas, .user_block, .vt_failure_block, .trip_phase_1, .trip_phase_2, .trip_phase_3,
    .general_trip, .irq);
  iep_far_side u_iep_far_side (
    .pclk, .presetn, .volt_set, .peak_set, .fund_set, .trip_phase_1, .trip_phase_2,
    .trip_phase_3, .general_trip, .meas, .seen_q, .width_q, .pulse_end);

  always #5 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic se);
    int n;
    apb_q.push_back('{e, m, se});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      chk("apb answer", 32'h1, 32'h0);
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 32'hffffffff, 1'b0);
  endtask

  task automatic drive(input logic [2:0][15:0] v, input logic [2:0][15:0] p,
                       input logic [2:0][15:0] f);
    @(posedge pclk);
    volt_set <= v;
    peak_set <= p;
    fund_set <= f;
  endtask

  task automatic wait_pulses();
    int n;
    n = 0;
    while (pulse_q.size() != 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      chk("trip pulse arrival", 32'h1, 32'h0);
      stop_test();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Result watcher: takes the oldest note whenever a result appears
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      chk("general trip", {31'h0, trip_phase_1 | trip_phase_2 | trip_phase_3},
          {31'h0, general_trip});
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      ae = apb_q.pop_front();
      if (!pwrite) begin
        chk("prdata", ae.exp, prdata & ae.mask);
      end
      chk("pslverr", {31'h0, ae.err}, {31'h0, pslverr});
    end
    if (pulse_end === 1'b1) begin
      if (pulse_q.size() == 0) begin
        chk("unexpected trip pulse", 32'h0, 32'h1);
      end else begin
        pe = pulse_q.pop_front();
        chk("trip phases", {29'h0, pe.seen}, {29'h0, seen_q});
        chk("pulse width", 32'h1, 32'(width_q >= pe.wmin && width_q <= pe.wmax));
      end
    end
  end

  initial begin
    repeat (50000) @(posedge pclk);
    chk("run length", 32'h1, 32'h0);
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(20983));
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, user_block, vt_failure_block} = '0;
    paddr = '0;
    pwdata = '0;
    volt_set = {3{16'h0064}};
    peak_set = '0;
    fund_set = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(iep_pkg::ADDR_CTRL, 32'h0);
    rd(iep_pkg::ADDR_CUR_THR, 32'h0c8);
    rd(iep_pkg::ADDR_VOLT_THR, 32'h05a);
    rd(iep_pkg::ADDR_PICKUP, 32'h3e8);
    rd(iep_pkg::ADDR_DROPOUT, 32'h064);
    rd(iep_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(iep_pkg::ADDR_IRQ_STAT, 32'h0);
    apb(1'b1, 8'h20, 32'h5, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 7; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i], CE[i]);
    end
    rv = 16'($urandom_range(3000, 20));
    wr(iep_pkg::ADDR_CUR_THR, {16'h0, rv});
    rd(iep_pkg::ADDR_CUR_THR, {16'h0, rv});
    wr(iep_pkg::ADDR_CUR_THR, 32'h0c8);
    wr(iep_pkg::ADDR_VOLT_THR, 32'h05a);
    wr(iep_pkg::ADDR_PICKUP, PICK);
    wr(iep_pkg::ADDR_DROPOUT, DROP);
    wr(iep_pkg::ADDR_IRQ_MASK, 32'h3);
    // Function off: dead voltage and heavy current must stay quiet
    drive('0, {3{16'h07d0}}, {3{16'h07d0}});
    repeat (ARM + 40) @(posedge pclk);
    chk("general trip while off", 32'h0, {31'h0, general_trip});
    chk("irq while off", 32'h0, {31'h0, irq});
    drive({3{16'h0064}}, '0, '0);
    // Energize in each mode, one phase each, wrong quantity on a neighbour
    for (int k = 0; k < 3; k++) begin
      msk = (k == 1) ? 32'h0 : 32'h3;
      wr(iep_pkg::ADDR_CTRL, {30'h0, (k == 1) ? iep_pkg::OP_FUND : iep_pkg::OP_PEAK});
      wr(iep_pkg::ADDR_IRQ_MASK, msk);
      lo = 16'($urandom_range(80, 0));
      hi = 16'($urandom_range(2000, 260));
      pk = '0;
      fd = '0;
      if (k == 1) begin
        fd[k] = hi;
        pk[(k + 1) % 3] = hi;
      end else begin
        pk[k] = hi;
        fd[(k + 1) % 3] = hi;
      end
      drive({3{lo}}, '0, '0);
      repeat (ARM) @(posedge pclk);
      rd(iep_pkg::ADDR_STATE, 32'h407);
      pulse_q.push_back('{3'(1 << k), (DROP - 1) * TICK - 4, DROP * TICK + 4});
      drive({3{16'h0064}}, pk, fd);
      wait_pulses();
      chk("irq level", {31'h0, msk[0]}, {31'h0, irq});
      rd(iep_pkg::ADDR_IRQ_STAT, 32'h3);
      repeat (3) @(posedge pclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      drive({3{16'h0064}}, '0, '0);
    end
    // One phase live, user block, transformer failure: no trip
    wr(iep_pkg::ADDR_CTRL, {30'h0, iep_pkg::OP_PEAK});
    for (int c = 0; c < 3; c++) begin
      vv = {3{lo}};
      if (c == 0) begin
        vv[2] = 16'h0064;
      end
      drive(vv, '0, '0);
      repeat (ARM) @(posedge pclk);
      user_block <= (c == 1);
      vt_failure_block <= (c == 2);
      repeat (3) @(posedge pclk);
      drive({3{16'h0064}}, {3{hi}}, {3{hi}});
      repeat (DROP * TICK + 20) @(posedge pclk);
      chk("general trip disabled", 32'h0, {31'h0, general_trip});
      drive({3{16'h0064}}, '0, '0);
      repeat (5) @(posedge pclk);
      user_block <= 1'b0;
      vt_failure_block <= 1'b0;
    end
    // Overcurrent hysteresis: 180 holds, 160 releases
    drive({3{lo}}, '0, '0);
    repeat (ARM) @(posedge pclk);
    pulse_q.push_back('{3'b001, 22, 32});
    drive({3{lo}}, {16'h0, 16'h0, 16'h00fa}, '0);
    repeat (5) @(posedge pclk);
    drive({3{lo}}, {16'h0, 16'h0, 16'h00b4}, '0);
    repeat (20) @(posedge pclk);
    drive({3{lo}}, {16'h0, 16'h0, 16'h00a0}, '0);
    wait_pulses();
    // Undervoltage hysteresis: 93 keeps the stage armed
    drive({3{16'h005d}}, '0, '0);
    repeat (DROP * TICK + 40) @(posedge pclk);
    pulse_q.push_back('{3'b001, 17, 36});
    drive({3{16'h005d}}, {16'h0, 16'h0, 16'h00fa}, '0);
    repeat (10) @(posedge pclk);
    drive({3{16'h0064}}, {16'h0, 16'h0, 16'h00fa}, '0);
    wait_pulses();
    chk("pending notes", 32'h0, 32'(apb_q.size() + pulse_q.size()));
    stop_test();
  end
endmodule

`default_nettype wire
